// ### hw/uart_chan_pkg.sv
// Package for one bridged serial channel: register offsets, field codes, defaults.
// Assumes a single 100 MHz clock and a plain register port.
package uart_chan_pkg;
   // ==========================================================
   // Register offsets (byte index on the plain port)
   localparam logic [3:0] REG_DIVISOR_LO = 4'h0;
   localparam logic [3:0] REG_DIVISOR_HI = 4'h1;
   localparam logic [3:0] REG_TX_MASK    = 4'h2;
   localparam logic [3:0] REG_FORMAT     = 4'h3;
   localparam logic [3:0] REG_FLOW       = 4'h4;
   localparam logic [3:0] REG_PIN_FUNC   = 4'h5;
   localparam logic [3:0] REG_WIDE       = 4'h6;
   localparam logic [3:0] REG_RESUME_CH  = 4'h7;
   localparam logic [3:0] REG_STOP_CH    = 4'h8;
   localparam logic [3:0] REG_TURN_DLY   = 4'h9;
   localparam logic [3:0] REG_ERR_STAT   = 4'ha;
   localparam logic [3:0] REG_GPIO_OUT   = 4'hb;
   localparam logic [3:0] REG_GPIO_DIR   = 4'hc;
   localparam logic [3:0] REG_GPIO_IN    = 4'hd;
   localparam logic [3:0] REG_LEVELS     = 4'he;
   // ==========================================================
   // Format fields
   localparam int FMT_BITS_LSB = 0;   // [1:0]: 0=7,1=8,2=9 bits
   localparam int FMT_PAR_EN   = 2;
   localparam int FMT_PAR_LSB  = 3;   // [4:3]: 0 odd,1 even,2 mark,3 space
   localparam int FMT_STOP2    = 5;
   localparam logic [1:0] BITS_7 = 2'h0;
   localparam logic [1:0] BITS_8 = 2'h1;
   localparam logic [1:0] BITS_9 = 2'h2;
   localparam logic [1:0] PAR_ODD  = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_MARK = 2'h2;
   // Flow control and pin-function codes
   localparam logic [2:0] FLOW_NONE  = 3'h0;
   localparam logic [2:0] FLOW_HW    = 3'h1;
   localparam logic [2:0] FLOW_SW    = 3'h2;
   localparam logic [2:0] FLOW_ADDR  = 3'h3;
   localparam logic [2:0] FLOW_ADDRT = 3'h4;
   localparam logic [2:0] PIN_GPIO   = 3'h0;
   localparam logic [2:0] PIN_RTSCTS = 3'h1;
   localparam logic [2:0] PIN_DTRDSR = 3'h2;
   localparam logic [2:0] PIN_XCVR   = 3'h3;
   // Error status bits
   localparam int ERR_PARITY  = 0;
   localparam int ERR_FRAMING = 1;
   localparam int ERR_BREAK   = 2;
   localparam int ERR_OVERRUN = 3;
   // ==========================================================
   // Reset values and timing
   localparam int unsigned CLK_HZ       = 100_000_000;
   localparam int unsigned DEFAULT_BAUD = 9600;
   localparam logic [15:0] DIVISOR_RST  = 16'((CLK_HZ + DEFAULT_BAUD / 2) / DEFAULT_BAUD);
   localparam logic [7:0]  FORMAT_RST   = 8'h01;   // 8 bits, no parity, 1 stop
   localparam logic [7:0]  RESUME_RST   = 8'h11;
   localparam logic [7:0]  STOP_RST     = 8'h13;
   localparam int          RTS_SLACK    = 32;      // free bytes kept for chars in flight
endpackage

// ### hw/uart_chan.sv
// One serial channel of a USB bridge: TX/RX FIFOs, framing, flow control, multidrop.
// Assumes bulk bytes arrive as a strobe with a CRC-good flag; all inputs are synchronous.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Reset to 9600, 8N1, no flow control
// - TX FIFO written only on CRC-good packets
// - Load shifter only when idle (busy clear)
// - Start, data LSB first, parity, stop bits
// - Seven/eight bits any parity; nine unparitied
// - Wide nine-bit TX takes two bytes per character
// - Wide mode set by its own register
// - Bit rate from divisor and clock mask
// - RX FIFO stores characters with error tags
// - Narrow RX delivers one data byte per character
// - Wide RX delivers second byte with flags
// - Parity checked except for nine bits
// - Wide overrun reflects whole FIFO state
// - Sticky error flags cleared by status read
// - Six lines are GPIO by default
// - Pin and flow 001: line5 RTS, line4 CTS
// - Request follows room; transmit follows clear input
// - Pin 010 flow 001: line3 DTR, line2 DSR
// - Stop/resume characters gate transmission
// - Modes 3/4 ninth bit marks address
// - Match drops address; mismatch disables receiver
// - Mode 4 transmits only while matched
// - Transceiver enable held 0..15 bit times
module uart_chan #(
   parameter int TX_DEPTH = 128,
   parameter int RX_DEPTH = 384
) (
   input  wire  logic        i_clk,
   input  wire  logic        i_rst_n,
   input  wire  logic        i_out_valid,
   input  wire  logic [7:0]  i_out_data,
   input  wire  logic        i_out_crc_ok,
   output logic              o_out_ready,
   input  wire  logic        i_in_ready,
   output logic              o_in_valid,
   output logic [7:0]        o_in_data,
   input  wire  logic [3:0]  i_addr,
   input  wire  logic [7:0]  i_wdata,
   input  wire  logic        i_wr,
   input  wire  logic        i_rd,
   output logic [7:0]        o_rdata,
   output logic              o_tx,
   input  wire  logic        i_rx,
   input  wire  logic [5:0]  i_io_line,
   output logic [5:0]        o_io_line,
   output logic [5:0]        o_io_line_oe_n
);
   localparam int TAW = $clog2(TX_DEPTH);
   localparam int RAW = $clog2(RX_DEPTH);

   // ==========================================================
   // Registers
   logic [15:0] div_q, div_d;
   logic [7:0]  mask_q, mask_d, fmt_q, fmt_d, flow_q, flow_d, pin_q, pin_d;
   logic        wide_q, wide_d;
   logic [7:0]  resume_q, resume_d, stop_q, stop_d;
   logic [3:0]  turn_q, turn_d, err_q, err_d;
   logic [5:0]  gout_q, gout_d, gdir_q, gdir_d;
   logic [7:0]  rdata_q, rdata_d;
   logic [3:0]  err_ev;
   logic        tx_hold_q, rx_en_q, rts_ok, tx_pop;

   function automatic logic [7:0] rd_mux(input logic [3:0] a);
      case (a)
         uart_chan_pkg::REG_DIVISOR_LO: rd_mux = div_q[7:0];
         uart_chan_pkg::REG_DIVISOR_HI: rd_mux = div_q[15:8];
         uart_chan_pkg::REG_TX_MASK:    rd_mux = mask_q;
         uart_chan_pkg::REG_FORMAT:     rd_mux = fmt_q;
         uart_chan_pkg::REG_FLOW:       rd_mux = flow_q;
         uart_chan_pkg::REG_PIN_FUNC:   rd_mux = pin_q;
         uart_chan_pkg::REG_WIDE:       rd_mux = {7'h00, wide_q};
         uart_chan_pkg::REG_RESUME_CH:  rd_mux = resume_q;
         uart_chan_pkg::REG_STOP_CH:    rd_mux = stop_q;
         uart_chan_pkg::REG_TURN_DLY:   rd_mux = {4'h0, turn_q};
         uart_chan_pkg::REG_ERR_STAT:   rd_mux = {4'h0, err_q};
         uart_chan_pkg::REG_GPIO_OUT:   rd_mux = {2'h0, gout_q};
         uart_chan_pkg::REG_GPIO_DIR:   rd_mux = {2'h0, gdir_q};
         uart_chan_pkg::REG_GPIO_IN:    rd_mux = {2'h0, i_io_line};
         uart_chan_pkg::REG_LEVELS:     rd_mux = {4'h0, rx_en_q, tx_hold_q, o_tx, rts_ok};
         default:                       rd_mux = 8'h00;
      endcase
   endfunction

   always_comb begin
      div_d = div_q; mask_d = mask_q; fmt_d = fmt_q; flow_d = flow_q; pin_d = pin_q;
      wide_d = wide_q; resume_d = resume_q; stop_d = stop_q; turn_d = turn_q;
      gout_d = gout_q; gdir_d = gdir_q;
      rdata_d = i_rd ? rd_mux(i_addr) : 8'h00;
      // Set wins over the read clear
      err_d = ((i_rd && i_addr == uart_chan_pkg::REG_ERR_STAT) ? 4'h0 : err_q) | err_ev;
      if (i_wr) begin
         case (i_addr)
            uart_chan_pkg::REG_DIVISOR_LO: div_d[7:0] = i_wdata;
            uart_chan_pkg::REG_DIVISOR_HI: div_d[15:8] = i_wdata;
            uart_chan_pkg::REG_TX_MASK:    mask_d = i_wdata;
            uart_chan_pkg::REG_FORMAT:     fmt_d = i_wdata;
            uart_chan_pkg::REG_FLOW:       flow_d = i_wdata;
            uart_chan_pkg::REG_PIN_FUNC:   pin_d = i_wdata;
            uart_chan_pkg::REG_WIDE:       wide_d = i_wdata[0];
            uart_chan_pkg::REG_RESUME_CH:  resume_d = i_wdata;
            uart_chan_pkg::REG_STOP_CH:    stop_d = i_wdata;
            uart_chan_pkg::REG_TURN_DLY:   turn_d = i_wdata[3:0];
            uart_chan_pkg::REG_GPIO_OUT:   gout_d = i_wdata[5:0];
            uart_chan_pkg::REG_GPIO_DIR:   gdir_d = i_wdata[5:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_q <= uart_chan_pkg::DIVISOR_RST;
         mask_q <= 8'h00; fmt_q <= uart_chan_pkg::FORMAT_RST; flow_q <= 8'h00;
         pin_q <= 8'h00; wide_q <= 1'b0; resume_q <= uart_chan_pkg::RESUME_RST;
         stop_q <= uart_chan_pkg::STOP_RST; turn_q <= 4'h0; err_q <= 4'h0;
         gout_q <= 6'h00; gdir_q <= 6'h00; rdata_q <= 8'h00;
      end else begin
         div_q <= div_d; mask_q <= mask_d; fmt_q <= fmt_d; flow_q <= flow_d;
         pin_q <= pin_d; wide_q <= wide_d; resume_q <= resume_d; stop_q <= stop_d;
         turn_q <= turn_d; err_q <= err_d; gout_q <= gout_d; gdir_q <= gdir_d;
         rdata_q <= rdata_d;
      end
   end

   // ==========================================================
   // Decoded modes
   logic [1:0] nbits;
   logic       par_en, nine, wide9, hw_fc, sw_fc, md_mode, md_tx;
   logic       rts_pins, dtr_pins, xcvr_pins;
   assign nbits    = fmt_q[uart_chan_pkg::FMT_BITS_LSB +: 2];
   assign nine     = (nbits == uart_chan_pkg::BITS_9);
   assign par_en   = fmt_q[uart_chan_pkg::FMT_PAR_EN] && !nine;
   assign wide9    = nine && wide_q;
   assign hw_fc    = flow_q[2:0] == uart_chan_pkg::FLOW_HW;
   assign sw_fc    = flow_q[2:0] == uart_chan_pkg::FLOW_SW;
   assign md_mode  = flow_q[2:0] == uart_chan_pkg::FLOW_ADDR || md_tx;
   assign md_tx    = flow_q[2:0] == uart_chan_pkg::FLOW_ADDRT;
   assign rts_pins = hw_fc && pin_q[2:0] == uart_chan_pkg::PIN_RTSCTS;
   assign dtr_pins = hw_fc && pin_q[2:0] == uart_chan_pkg::PIN_DTRDSR;
   assign xcvr_pins = pin_q[2:0] == uart_chan_pkg::PIN_XCVR;

   function automatic logic par_of(input logic [7:0] d, input logic [1:0] n,
                                   input logic [1:0] kind);
      logic x;
      x = ^(n == uart_chan_pkg::BITS_7 ? {1'b0, d[6:0]} : d);
      case (kind)
         uart_chan_pkg::PAR_ODD:  par_of = ~x;
         uart_chan_pkg::PAR_EVEN: par_of = x;
         uart_chan_pkg::PAR_MARK: par_of = 1'b1;
         default:                 par_of = 1'b0;
      endcase
   endfunction

   // ==========================================================
   // Bit bit_rate_divisor sets the period, mask drops ticks for fine trim
   logic [15:0] bcnt_q, bcnt_d;
   logic [7:0]  mrot_q, mrot_d;
   logic        tick_q, tick_d;
   always_comb begin
      bcnt_d = bcnt_q + 16'h0001;
      mrot_d = mrot_q;
      tick_d = 1'b0;
      if (bcnt_q + 16'h0001 >= div_q) begin
         bcnt_d = 16'h0000;
         mrot_d = {mrot_q[6:0], mrot_q[7]};
         tick_d = !(mask_q[0] && mrot_q[0]);
      end
      // Restart on load so the start bit is a full bit time
      if (tx_pop) begin
         bcnt_d = 16'h0001;
         tick_d = 1'b0;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bcnt_q <= 16'h0000; mrot_q <= 8'h01; tick_q <= 1'b0;
      end else begin
         bcnt_q <= bcnt_d; mrot_q <= mrot_d; tick_q <= tick_d;
      end
   end

   // ==========================================================
   // TX FIFO and shifter
   logic [7:0]   txm [TX_DEPTH];
   logic [TAW:0] tx_cnt_q, tx_cnt_d;
   logic [TAW-1:0] txw_q, txw_d, txr_q, txr_d;
   logic         tx_push, tx_avail, rdy_q, rdy_d;
   logic [10:0]  tsh_q, tsh_d;  // transmit_shift_reg
   logic [3:0]   tbits_q, tbits_d;
   logic         tbusy_q, tbusy_d, tx_q, tx_d, tx_hold_d;
   logic [3:0]   turn_cnt_q, turn_cnt_d;
   logic         txen_q, txen_d;
   logic         cts_ok, matched_q;
   logic [7:0]   tx_b0, tx_b1;

   assign o_out_ready = rdy_q;
   assign tx_push  = i_out_valid && i_out_crc_ok && o_out_ready;
   assign tx_b0    = txm[txr_q];
   assign tx_b1    = txm[TAW'((txr_q + 1) % TX_DEPTH)];
   assign tx_avail = wide9 ? tx_cnt_q >= 2 : tx_cnt_q >= 1;
   assign cts_ok   = !((rts_pins && i_io_line[4]) || (dtr_pins && i_io_line[2]));
   assign tx_pop   = !tbusy_q && tx_avail && cts_ok && !tx_hold_q
                     && (!md_tx || matched_q);

   always_comb begin
      logic [8:0] d;
      logic [3:0] n;
      d = 9'h000;
      n = 4'h0;
      txw_d = tx_push ? TAW'((txw_q + 1) % TX_DEPTH) : txw_q;
      txr_d = txr_q;
      tx_cnt_d = tx_cnt_q + (tx_push ? 1'b1 : 1'b0);
      tsh_d = tsh_q; tbits_d = tbits_q; tbusy_d = tbusy_q; tx_d = tx_q;
      if (tx_pop) begin
         // Ninth bit is zero unless wide mode supplies it
         d = wide9 ? {tx_b1[0], tx_b0} : {1'b0, tx_b0};
         txr_d = TAW'((txr_q + (wide9 ? 2 : 1)) % TX_DEPTH);
         tx_cnt_d = tx_cnt_d - (wide9 ? (TAW+1)'(2) : (TAW+1)'(1));
         n = nbits == uart_chan_pkg::BITS_7 ? 4'd7 : nbits == uart_chan_pkg::BITS_8 ? 4'd8 : 4'd9;
         if (par_en) begin
            d[n] = par_of(tx_b0, nbits, fmt_q[uart_chan_pkg::FMT_PAR_LSB +: 2]);
            n = n + 4'd1;
         end
         // Frame LSB first: start, data, parity, stops
         tsh_d = {2'b11, d} | (11'h7ff << n);
         tbits_d = n + 4'd1 + (fmt_q[uart_chan_pkg::FMT_STOP2] ? 4'd2 : 4'd1);
         tbusy_d = 1'b1;
         tx_d = 1'b0;
      end else if (tbusy_q && tick_q) begin
         if (tbits_q == 4'd1) begin
            tbusy_d = 1'b0;
            tx_d = 1'b1;
         end else begin
            tx_d = tsh_q[0];
            tsh_d = {1'b1, tsh_q[10:1]};
         end
         tbits_d = tbits_q - 4'd1;
      end
      rdy_d = tx_cnt_d < TX_DEPTH;
   end
   always_ff @(posedge i_clk) if (tx_push) txm[txw_q] <= i_out_data;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_cnt_q <= '0; txw_q <= '0; txr_q <= '0; tsh_q <= 11'h7ff;
         tbits_q <= 4'h0; tbusy_q <= 1'b0; tx_q <= 1'b1; rdy_q <= 1'b1;
      end else begin
         tx_cnt_q <= tx_cnt_d; txw_q <= txw_d; txr_q <= txr_d; tsh_q <= tsh_d;
         tbits_q <= tbits_d; tbusy_q <= tbusy_d; tx_q <= tx_d; rdy_q <= rdy_d;
      end
   end
   assign o_tx = tx_q;

   // Transceiver enable: held for turn_q extra bit times after the last stop
   always_comb begin
      turn_cnt_d = turn_cnt_q;
      txen_d = txen_q;
      if (tbusy_q || tx_pop) begin
         txen_d = 1'b1;
         turn_cnt_d = turn_q;
      end else if (txen_q) begin
         if (turn_cnt_q == 4'h0) txen_d = 1'b0;
         else if (tick_q) turn_cnt_d = turn_cnt_q - 4'h1;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         turn_cnt_q <= 4'h0; txen_q <= 1'b0;
      end else begin
         turn_cnt_q <= turn_cnt_d; txen_q <= txen_d;
      end
   end

   // ==========================================================
   // Receiver: first sample half a bit after the start edge
   logic [15:0] scnt_q, scnt_d;
   logic [3:0]  rbits_q, rbits_d;
   logic        ract_q, ract_d, rx_en_d, matched_d;
   logic [9:0]  rsh_q, rsh_d;   // receive_shift_reg
   logic        rdone;
   logic [8:0]  rdat;
   logic        rpar, perr, ferr, berr, is_addr, amatch, store;
   logic [3:0]  need;
   logic [8:0]  rxm [RX_DEPTH];  // data byte plus ninth bit
   logic [3:0]  rxe [RX_DEPTH];  // parity, framing, break tags; overrun bit stored as 0
   logic [RAW:0] rx_cnt_q, rx_cnt_d;
   logic [RAW-1:0] rxw_q, rxw_d, rxr_q, rxr_d;
   logic        half_q, half_d, ovr_q, ovr_d, ivalid_q, ivalid_d;
   logic [7:0]  idata_q, idata_d;

   assign need = (nbits == uart_chan_pkg::BITS_7 ? 4'd7 : nbits == uart_chan_pkg::BITS_8
                  ? 4'd8 : 4'd9) + (par_en ? 4'd1 : 4'd0);
   always_comb begin
      scnt_d = scnt_q + 16'h0001;
      rbits_d = rbits_q; ract_d = ract_q; rsh_d = rsh_q;
      rdone = 1'b0;
      if (!ract_q) begin
         scnt_d = 16'h0000;
         if (!i_rx) begin
            ract_d = 1'b1; rbits_d = 4'h0;
         end
      end else if (scnt_q + 16'h0001 >= (rbits_q == 4'h0 ? {1'b0, div_q[15:1]} : div_q)) begin
         scnt_d = 16'h0000;
         if (rbits_q == 4'h0 && i_rx) ract_d = 1'b0;      // false start
         else if (rbits_q == need + 4'd1) begin
            ract_d = 1'b0; rdone = 1'b1;
         end else rsh_d = {i_rx, rsh_q[9:1]};
         rbits_d = rbits_q + 4'h1;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scnt_q <= 16'h0000; rbits_q <= 4'h0; ract_q <= 1'b0;
         rsh_q <= 10'h000;
      end else begin
         scnt_q <= scnt_d; rbits_q <= rbits_d; ract_q <= ract_d;
         rsh_q <= rsh_d;
      end
   end

   // Character decode; stop bit is i_rx at the last sample
   always_comb begin
      logic [9:0] a;
      a = rsh_q >> (4'd10 - rbits_q + 4'd1);
      rdat = {(nine || par_en) ? a[need-1] : 1'b0, a[7:0]};
      if (nbits == uart_chan_pkg::BITS_7) rdat[7] = par_en ? a[7] : 1'b0;
      rpar = par_en ? a[need-1] : 1'b0;
   end
   assign perr = par_en &&
                 rpar != par_of(rdat[7:0], nbits, fmt_q[uart_chan_pkg::FMT_PAR_LSB +: 2]);
   assign ferr = !i_rx;
   assign berr = ferr && rdat == 9'h000;
   assign is_addr = md_mode && rdat[need-1 > 8 ? 8 : need-1] && (nine || par_en);
   assign amatch = rdat[7:0] == resume_q || rdat[7:0] == stop_q;

   always_comb begin
      rx_en_d = rx_en_q;
      matched_d = matched_q;
      tx_hold_d = tx_hold_q;
      store = 1'b0;
      if (!md_mode) begin
         rx_en_d = 1'b1; matched_d = 1'b0;
      end
      if (!sw_fc) tx_hold_d = 1'b0;
      if (rdone) begin
         if (is_addr) begin
            rx_en_d = amatch;
            matched_d = amatch;
         end else if (sw_fc && rdat[7:0] == stop_q) tx_hold_d = 1'b1;
         else if (sw_fc && rdat[7:0] == resume_q) tx_hold_d = 1'b0;
         else store = rx_en_q || !md_mode;
      end
   end
   assign err_ev = rdone ? {store && rx_cnt_q >= RX_DEPTH, berr, ferr, perr} : 4'h0;

   // ==========================================================
   // RX FIFO and bulk-in byte stream
   always_comb begin
      logic w;
      w = store && rx_cnt_q < RX_DEPTH;
      rxw_d = w ? RAW'((rxw_q + 1) % RX_DEPTH) : rxw_q;
      rxr_d = rxr_q;
      rx_cnt_d = rx_cnt_q + (w ? 1'b1 : 1'b0);
      ovr_d = (store && !w) ? 1'b1 : (rx_cnt_q == 0 ? 1'b0 : ovr_q);
      half_d = half_q;
      ivalid_d = ivalid_q;
      idata_d = idata_q;
      if (ivalid_q && i_in_ready) begin
         ivalid_d = 1'b0;
         if (wide_q && !half_q) half_d = 1'b1;
         else begin
            half_d = 1'b0;
            rxr_d = RAW'((rxr_q + 1) % RX_DEPTH);
            rx_cnt_d = rx_cnt_d - 1'b1;
         end
      end else if (!ivalid_q && rx_cnt_q != 0) begin
         ivalid_d = 1'b1;
         if (!wide_q) idata_d = rxm[rxr_q][7:0];
         else if (!half_q) idata_d = rxm[rxr_q][7:0];
         else idata_d = {4'h0, ovr_q, rxe[rxr_q][uart_chan_pkg::ERR_FRAMING],
                         rxe[rxr_q][uart_chan_pkg::ERR_BREAK], rxm[rxr_q][8]};
      end
   end
   always_ff @(posedge i_clk) begin
      if (store && rx_cnt_q < RX_DEPTH) begin
         rxm[rxw_q] <= rdat;
         rxe[rxw_q] <= {1'b0, berr, ferr, perr};
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_cnt_q <= '0; rxw_q <= '0; rxr_q <= '0; half_q <= 1'b0; ovr_q <= 1'b0;
         ivalid_q <= 1'b0; idata_q <= 8'h00; rx_en_q <= 1'b1; matched_q <= 1'b0;
         tx_hold_q <= 1'b0;
      end else begin
         rx_cnt_q <= rx_cnt_d; rxw_q <= rxw_d; rxr_q <= rxr_d; half_q <= half_d;
         ovr_q <= ovr_d; ivalid_q <= ivalid_d; idata_q <= idata_d;
         rx_en_q <= rx_en_d; matched_q <= matched_d; tx_hold_q <= tx_hold_d;
      end
   end
   assign o_in_valid = ivalid_q;
   assign o_in_data  = idata_q;
   assign o_rdata    = rdata_q;
   assign rts_ok = rx_cnt_q + uart_chan_pkg::RTS_SLACK < RX_DEPTH;

   // ==========================================================
   // Line pins: GPIO unless a mode claims them
   logic [5:0] lo_q, lo_d, loe_q, loe_d;
   always_comb begin
      lo_d = gout_q;
      loe_d = ~gdir_q;
      if (rts_pins) begin
         lo_d[5] = !rts_ok; loe_d[5] = 1'b0; loe_d[4] = 1'b1;
      end else if (xcvr_pins) begin
         lo_d[5] = txen_q; loe_d[5] = 1'b0;
      end
      if (dtr_pins) begin
         lo_d[3] = !rts_ok; loe_d[3] = 1'b0; loe_d[2] = 1'b1;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lo_q <= 6'h00; loe_q <= 6'h3f;
      end else begin
         lo_q <= lo_d; loe_q <= loe_d;
      end
   end
   assign o_io_line = lo_q;
   assign o_io_line_oe_n = loe_q;
endmodule
`default_nettype wire

// ### testbench/uart_remote.sv
// Remote serial partner: frame receiver on the channel output, frame sender on its input.
// Assumes the bit time in clocks equals the divisor that the bench programs.
`timescale 1ns/1ns
`default_nettype none
module uart_remote #(
   parameter int BIT = 8
) (
   input  wire logic i_clk,
   input  wire logic i_line,
   output logic      o_line
);
   int         nbits = 8;
   int         n_got = 0;
   logic [8:0] got = 9'h000;
   initial o_line = 1'b1;
   // ==========================================
   // Receive: sample mid-bit, data LSB first
   always begin : rx_frame
      logic [8:0] w;
      @(negedge i_line);
      w = 9'h000;
      repeat (BIT / 2) @(posedge i_clk);
      for (int i = 0; i < nbits; i++) begin
         repeat (BIT) @(posedge i_clk);
         w[i] = i_line;
      end
      // Count at mid stop bit so a back-to-back start edge is not missed
      repeat (BIT) @(posedge i_clk);
      got = w;
      n_got++;
   end
   task automatic send(input logic [8:0] d, input int nb, input logic stp);
      o_line <= 1'b0;
      repeat (BIT) @(posedge i_clk);
      for (int i = 0; i < nb; i++) begin
         o_line <= d[i];
         repeat (BIT) @(posedge i_clk);
      end
      o_line <= stp;
      repeat (BIT) @(posedge i_clk);
      o_line <= 1'b1;
      repeat (BIT) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

// ### testbench/uart_chan_checker.sv
// Port-level checker for the serial channel, bound into its top module.
// Assumes the programmed divisor is never below 8 clocks per bit.
`timescale 1ns/1ns
`default_nettype none
module uart_chan_checker (
   input wire logic       i_clk,
   input wire logic       i_rst_n,
   input wire logic       i_out_valid,
   input wire logic       i_out_crc_ok,
   input wire logic       o_out_ready,
   input wire logic       i_in_ready,
   input wire logic       o_in_valid,
   input wire logic [7:0] o_in_data,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic       o_tx,
   input wire logic       i_rx,
   input wire logic [5:0] o_io_line_oe_n
);
   logic cfg_q, sent_q, heard_q;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_q   <= 1'b0;
         sent_q  <= 1'b0;
         heard_q <= 1'b0;
      end else begin
         cfg_q   <= cfg_q | i_wr;
         sent_q  <= sent_q | (i_out_valid & i_out_crc_ok & o_out_ready);
         heard_q <= heard_q | !i_rx;
      end
   end
   // ==========================================
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_low_bit;  (!o_tx)[*8]; endsequence
   sequence s_high_bit; o_tx[*8]; endsequence
   a_low_bit_len:
      assert property ($fell(o_tx) |-> s_low_bit) else $error("tx low bit too short");
   a_high_bit_len:
      assert property ($rose(o_tx) |-> s_high_bit) else $error("tx high bit too short");
   a_rdata_quiet:
      assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata without read");
   a_gpio_default:
      assert property (!cfg_q |-> o_io_line_oe_n == 6'h3f) else $error("line driven at reset");
   a_tx_quiet:
      assert property (!sent_q |-> o_tx) else $error("tx without accepted byte");
   a_in_quiet:
      assert property (!heard_q |-> !o_in_valid) else $error("bulk-in without rx");
   a_in_hold:
      assert property (o_in_valid && !i_in_ready |=> o_in_valid) else $error("valid dropped");
   a_in_stable:
      assert property (o_in_valid && !i_in_ready |=> $stable(o_in_data)) else $error("data moved");
endmodule
bind uart_chan uart_chan_checker chk_i (.i_clk, .i_rst_n, .i_out_valid, .i_out_crc_ok,
   .o_out_ready, .i_in_ready, .o_in_valid, .o_in_data, .i_wr, .i_rd, .o_rdata, .o_tx, .i_rx,
   .o_io_line_oe_n);
`default_nettype wire

// ### testbench/uart_chan_tb.sv
// Bench for one serial channel: registers, bulk bytes and serial frames both ways.
// Assumes the remote model and checker compile first; divisor set to 8 clocks per bit.
`timescale 1ns/1ns
`default_nettype none
module uart_chan_tb;
   logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic       ov = 1'b0, crc = 1'b0, in_rdy = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wd = 8'h00, od = 8'h00;
   logic [7:0] rdata, in_data;
   logic       in_valid, o_rdy, tx, rx;
   logic [5:0] io_in = 6'h00, io_out, io_oe_n;
   int         n_mismatch = 0, tests_run = 0;
   always #5 clk = ~clk;
   uart_chan uut (.i_clk(clk), .i_rst_n(rst_n), .i_out_valid(ov), .i_out_data(od),
      .i_out_crc_ok(crc), .o_out_ready(o_rdy), .i_in_ready(in_rdy), .o_in_valid(in_valid),
      .o_in_data(in_data), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .o_tx(tx), .i_rx(rx), .i_io_line(io_in), .o_io_line(io_out), .o_io_line_oe_n(io_oe_n));
   uart_remote #(.BIT(8)) rem (.i_clk(clk), .i_line(tx), .o_line(rx));
   // ==========================================
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(9'(rdata), 9'(e));
   endtask
   task automatic put(input logic [7:0] d, input logic ok);
      @(posedge clk);
      ov <= 1'b1;
      od <= d;
      crc <= ok;
      @(posedge clk);
      ov <= 1'b0;
   endtask
   // Ready held low at first so the stream must wait
   task automatic get(input logic [7:0] e);
      repeat (300) begin
         @(negedge clk);
         if (in_valid === 1'b1) break;
      end
      chk(9'(in_data), 9'(e));
      @(posedge clk);
      in_rdy <= 1'b1;
      @(posedge clk);
      in_rdy <= 1'b0;
   endtask
   task automatic tx_chk(input int n, input logic [8:0] e);
      repeat (400) begin
         @(negedge clk);
         if (rem.n_got >= n) break;
      end
      chk(rem.got, e);
   endtask
   task automatic close_out();
      if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      close_out();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(uart_chan_pkg::REG_FORMAT, 8'h01);
      rd_chk(uart_chan_pkg::REG_DIVISOR_LO, uart_chan_pkg::DIVISOR_RST[7:0]);
      rd_chk(uart_chan_pkg::REG_DIVISOR_HI, uart_chan_pkg::DIVISOR_RST[15:8]);
      rd_chk(uart_chan_pkg::REG_FLOW, 8'h00);
      rd_chk(4'hf, 8'h00);
      wr_reg(uart_chan_pkg::REG_DIVISOR_LO, 8'h08);
      wr_reg(uart_chan_pkg::REG_DIVISOR_HI, 8'h00);
      wr_reg(uart_chan_pkg::REG_TX_MASK, 8'h00);
      put(8'h55, 1'b0);
      repeat (200) @(posedge clk);
      chk(9'(rem.n_got), 9'h000);
      put(8'ha5, 1'b1);
      put(8'h3c, 1'b1);
      tx_chk(1, 9'h0a5);
      tx_chk(2, 9'h03c);
      rem.send(9'h0c3, 8, 1'b1);
      get(8'hc3);
      wr_reg(uart_chan_pkg::REG_WIDE, 8'h01);
      rem.send(9'h05a, 8, 1'b0);
      get(8'h5a);
      get(8'h04);
      rd_chk(uart_chan_pkg::REG_ERR_STAT, 8'h02);
      rd_chk(uart_chan_pkg::REG_ERR_STAT, 8'h00);
      wr_reg(uart_chan_pkg::REG_FORMAT, 8'h02);
      rem.nbits = 9;
      put(8'h3c, 1'b1);
      put(8'h01, 1'b1);
      tx_chk(3, 9'h13c);
      rem.send(9'h1aa, 9, 1'b1);
      get(8'haa);
      get(8'h01);
      wr_reg(uart_chan_pkg::REG_WIDE, 8'h00);
      put(8'hff, 1'b1);
      tx_chk(4, 9'h0ff);
      wr_reg(uart_chan_pkg::REG_PIN_FUNC, 8'h01);
      wr_reg(uart_chan_pkg::REG_FLOW, 8'h01);
      io_in <= 6'h10;
      put(8'h66, 1'b1);
      repeat (200) @(posedge clk);
      chk(9'({o_rdy, io_oe_n[5], io_out[5]}), 9'h004);
      chk(9'(rem.n_got), 9'h004);
      io_in <= 6'h00;
      tx_chk(5, 9'h066);
      close_out();
   end
endmodule
`default_nettype wire
